//--- logic/crri_core.v
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
`include "crri_map.vh"
module crri_core #(
  parameter PWM_W = 4
) (
  clk,
  rst_b,
  ev_por,
  ev_bor,
  ev_clr,
  ev_wdt_rst,
  ev_rst_inst,
  ev_stk_full,
  ev_stk_unf,
  ev_wake_wdt,
  ev_wake_irq,
  wake_hi_prio,
  wake_ic_bits,
  wake_pir_bits,
  in_sleep,
  pc_now,
  brownout_config_field,
  osc_frees_ra67,
  pwm_pin_reset_mode,
  port_a_in,
  addr,
  wdata,
  wr,
  rd,
  rdata,
  pc_out,
  port_a_latch_out,
  port_a_dir_out,
  pwm_output_enable,
  irq
);
  input wire clk;
  input wire rst_b;
  input wire ev_por;
  input wire ev_bor;
  input wire ev_clr;
  input wire ev_wdt_rst;
  input wire ev_rst_inst;
  input wire ev_stk_full;
  input wire ev_stk_unf;
  input wire ev_wake_wdt;
  input wire ev_wake_irq;
  input wire wake_hi_prio;
  input wire [7:0] wake_ic_bits;
  input wire [7:0] wake_pir_bits;
  input wire in_sleep;
  input wire [20:0] pc_now;
  input wire [1:0] brownout_config_field;
  input wire osc_frees_ra67;
  input wire pwm_pin_reset_mode;
  input wire [7:0] port_a_in;
  input wire [4:0] addr;
  input wire [7:0] wdata;
  input wire wr;
  input wire rd;
  output reg [7:0] rdata;
  output reg [20:0] pc_out;
  output reg [7:0] port_a_latch_out;
  output reg [7:0] port_a_dir_out;
  output reg [PWM_W-1:0] pwm_output_enable;
  output reg irq;

  // =====================================================================
  // pin synchronisers
  reg [7:0] pa_s1_reg;
  reg [7:0] pa_s2_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pa_s1_reg <= 8'h00;
      pa_s2_reg <= 8'h00;
    end else begin
      pa_s1_reg <= port_a_in;
      pa_s2_reg <= pa_s1_reg;
    end
  end

  // =====================================================================
  // event decode
  // power-on priority
  wire por_any = ev_por | ev_bor;
  wire oth_rst = ~por_any &
    (ev_clr | ev_wdt_rst | ev_rst_inst | ev_stk_full | ev_stk_unf);
  wire wake = ~por_any & ~oth_rst & (ev_wake_wdt | ev_wake_irq);

  function [7:0] ra_mask;
    input freed;
    begin
      ra_mask = freed ? 8'hFF : 8'h3F;
    end
  endfunction

  // =====================================================================
  // registers
  reg [4:0] stack_top_upper_reg;
  reg [7:0] stack_top_high_reg, stack_top_low_reg, sp_reg;
  reg [4:0] pclu_reg;
  reg [7:0] pclh_reg;
  reg [5:0] tbu_reg;
  reg [7:0] tbh_reg, tbl_reg, tlat_reg, prh_reg, prl_reg;
  reg [7:0] ic1_reg, ic2_reg, ic3_reg, pir_reg;
  reg [3:0] p0h_reg, p1h_reg, bsel_reg;
  reg [7:0] p0l_reg, p1l_reg, wrk_reg, rcs_reg;
  reg [1:0] ist_reg, imsk_reg;
  wire gie = ic1_reg[`CRRI_IC1_GLOBAL_IRQ_ENABLE_HIGH] | ic1_reg[`CRRI_IC1_GLOBAL_IRQ_ENABLE_LOW];
  wire vec = ev_wake_irq & gie;
  wire sw = wr & ~por_any & ~oth_rst & ~wake;
  wire [1:0] ev_set = {por_any | oth_rst, wake};

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      // undefined regs given zero only for determinism
      stack_top_upper_reg <= 5'h00; stack_top_high_reg <= 8'h00; stack_top_low_reg <= 8'h00;
      sp_reg <= 8'h00; pclu_reg <= 5'h00; pclh_reg <= 8'h00;
      pc_out <= 21'h000000; tbu_reg <= 6'h00; tbh_reg <= 8'h00;
      tbl_reg <= 8'h00; tlat_reg <= 8'h00; prh_reg <= 8'h00;
      prl_reg <= 8'h00; ic1_reg <= 8'h00; ic2_reg <= `CRRI_RST_IC2;
      ic3_reg <= `CRRI_RST_IC3; pir_reg <= 8'h00; p0h_reg <= 4'h0;
      p1h_reg <= 4'h0; bsel_reg <= 4'h0; p0l_reg <= 8'h00;
      p1l_reg <= 8'h00; wrk_reg <= 8'h00; rcs_reg <= 8'h5E;
      port_a_latch_out <= 8'h00; port_a_dir_out <= 8'h3F;
      pwm_output_enable <= {PWM_W{1'b0}};
      ist_reg <= 2'h0; imsk_reg <= 2'h0;
    end else if (por_any | oth_rst) begin
      stack_top_upper_reg <= 5'h00; stack_top_high_reg <= 8'h00; stack_top_low_reg <= 8'h00;
      pclu_reg <= 5'h00; pclh_reg <= 8'h00; pc_out <= 21'h000000;
      tbu_reg <= 6'h00; tbh_reg <= 8'h00; tbl_reg <= 8'h00;
      tlat_reg <= 8'h00; ic2_reg <= `CRRI_RST_IC2;
      ic3_reg <= `CRRI_RST_IC3; p0h_reg <= 4'h0; p1h_reg <= 4'h0;
      bsel_reg <= 4'h0;
      // keep bit0 and stack flags on other resets
      ic1_reg <= {7'h00, por_any ? 1'b0 : ic1_reg[0]};
      sp_reg <= {por_any ? 2'b00 : sp_reg[7:6], 6'h00};
      if (oth_rst & ev_stk_full)
        sp_reg[`CRRI_SP_FULL] <= 1'b1;
      if (oth_rst & ev_stk_unf)
        sp_reg[`CRRI_SP_UNF] <= 1'b1;
      port_a_latch_out <= 8'h00;
      port_a_dir_out <= ra_mask(osc_frees_ra67);
      pwm_output_enable <= {PWM_W{~pwm_pin_reset_mode}};
      rcs_reg[`CRRI_RC_SOFT_BROWNOUT_ENABLE] <= ev_por | ((brownout_config_field ==
        `CRRI_BOR_SOFT) & rcs_reg[`CRRI_RC_SOFT_BROWNOUT_ENABLE]);
      if (ev_por) begin
        rcs_reg[`CRRI_RC_RI] <= 1'b1; rcs_reg[`CRRI_RC_TO] <= 1'b1;
        rcs_reg[`CRRI_RC_PD] <= 1'b1; rcs_reg[`CRRI_RC_POR] <= 1'b0;
        rcs_reg[`CRRI_RC_BOR] <= 1'b0;
      end else if (ev_bor) begin
        rcs_reg[`CRRI_RC_RI] <= 1'b1; rcs_reg[`CRRI_RC_TO] <= 1'b1;
        rcs_reg[`CRRI_RC_PD] <= 1'b1; rcs_reg[`CRRI_RC_BOR] <= 1'b0;
      end else if (ev_rst_inst) begin
        rcs_reg[`CRRI_RC_RI] <= 1'b0;
      end else if (ev_wdt_rst) begin
        rcs_reg[`CRRI_RC_TO] <= 1'b0;
      end else if (ev_clr & in_sleep) begin
        rcs_reg[`CRRI_RC_TO] <= 1'b1; rcs_reg[`CRRI_RC_PD] <= 1'b0;
      end
      ist_reg <= ist_reg | ev_set;
    end else if (wake) begin
      ic1_reg <= ic1_reg | wake_ic_bits;
      pir_reg <= pir_reg | wake_pir_bits;
      rcs_reg[`CRRI_RC_PD] <= 1'b0;
      if (ev_wake_wdt)
        rcs_reg[`CRRI_RC_TO] <= 1'b0;
      if (vec) begin
        {stack_top_upper_reg, stack_top_high_reg, stack_top_low_reg} <= pc_now;
        sp_reg[4:0] <= sp_reg[4:0] + 5'h01;
        pc_out <= wake_hi_prio ? `CRRI_VEC_HI : `CRRI_VEC_LO;
      end else begin
        pc_out <= pc_now + `CRRI_PC_STEP;
      end
      ist_reg <= ist_reg | ev_set;
    end else begin
      if (sw) begin
        case (addr)
          `CRRI_A_STACK_TOP_UPPER: stack_top_upper_reg <= wdata[4:0];
          `CRRI_A_STACK_TOP_HIGH: stack_top_high_reg <= wdata;
          `CRRI_A_STACK_TOP_LOW: stack_top_low_reg <= wdata;
          `CRRI_A_SPTR: sp_reg <= wdata & `CRRI_SP_MASK;
          `CRRI_A_PCLU: pclu_reg <= wdata[4:0];
          `CRRI_A_PCLH: pclh_reg <= wdata;
          `CRRI_A_PCL: pc_out <= {pclu_reg, pclh_reg, wdata};
          `CRRI_A_TBU: tbu_reg <= wdata[5:0];
          `CRRI_A_TBH: tbh_reg <= wdata;
          `CRRI_A_TBL: tbl_reg <= wdata;
          `CRRI_A_TLAT: tlat_reg <= wdata;
          `CRRI_A_PRH: prh_reg <= wdata;
          `CRRI_A_PRL: prl_reg <= wdata;
          `CRRI_A_IC1: ic1_reg <= wdata;
          `CRRI_A_IC2: ic2_reg <= wdata;
          `CRRI_A_IC3: ic3_reg <= wdata;
          `CRRI_A_P0H: p0h_reg <= wdata[3:0];
          `CRRI_A_P0L: p0l_reg <= wdata;
          `CRRI_A_WRK: wrk_reg <= wdata;
          `CRRI_A_P1H: p1h_reg <= wdata[3:0];
          `CRRI_A_P1L: p1l_reg <= wdata;
          `CRRI_A_BSEL: bsel_reg <= wdata[3:0];
          `CRRI_A_RCS: rcs_reg <= wdata & 8'h5F;
          `CRRI_A_PIRF: pir_reg <= wdata;
          // pins 6 and 7 only when freed
          `CRRI_A_PORT_A_PINS: port_a_latch_out <= wdata & ra_mask(osc_frees_ra67);
          `CRRI_A_PWM: port_a_dir_out <= wdata & ra_mask(osc_frees_ra67);
          `CRRI_A_IMSK: imsk_reg <= wdata[1:0];
          default: ;
        endcase
      end
      // set wins over write-one clear: no event reaches here
      if (sw && addr == `CRRI_A_IST)
        ist_reg <= ist_reg & ~wdata[1:0];
    end
  end

  // =====================================================================
  // read path and interrupt
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      irq <= |(ist_reg & imsk_reg);
      if (rd) begin
        case (addr)
          `CRRI_A_STACK_TOP_UPPER: rdata <= {3'h0, stack_top_upper_reg};
          `CRRI_A_STACK_TOP_HIGH: rdata <= stack_top_high_reg;
          `CRRI_A_STACK_TOP_LOW: rdata <= stack_top_low_reg;
          `CRRI_A_SPTR: rdata <= sp_reg & `CRRI_SP_MASK;
          `CRRI_A_PCLU: rdata <= {3'h0, pclu_reg};
          `CRRI_A_PCLH: rdata <= pclh_reg;
          `CRRI_A_PCL: rdata <= pc_out[7:0];
          `CRRI_A_TBU: rdata <= {2'h0, tbu_reg};
          `CRRI_A_TBH: rdata <= tbh_reg;
          `CRRI_A_TBL: rdata <= tbl_reg;
          `CRRI_A_TLAT: rdata <= tlat_reg;
          `CRRI_A_PRH: rdata <= prh_reg;
          `CRRI_A_PRL: rdata <= prl_reg;
          `CRRI_A_IC1: rdata <= ic1_reg;
          `CRRI_A_IC2: rdata <= ic2_reg;
          `CRRI_A_IC3: rdata <= ic3_reg;
          `CRRI_A_P0H: rdata <= {4'h0, p0h_reg};
          `CRRI_A_P0L: rdata <= p0l_reg;
          `CRRI_A_WRK: rdata <= wrk_reg;
          `CRRI_A_P1H: rdata <= {4'h0, p1h_reg};
          `CRRI_A_P1L: rdata <= p1l_reg;
          `CRRI_A_BSEL: rdata <= {4'h0, bsel_reg};
          `CRRI_A_RCS: rdata <= rcs_reg & 8'h5F;
          `CRRI_A_PIRF: rdata <= pir_reg;
          `CRRI_A_PORT_A_PINS: rdata <= pa_s2_reg & ra_mask(osc_frees_ra67);
          `CRRI_A_PWM: rdata <= port_a_dir_out;
          `CRRI_A_IST: rdata <= {6'h00, ist_reg};
          `CRRI_A_IMSK: rdata <= {6'h00, imsk_reg};
          default: rdata <= 8'h00;
        endcase
      end else begin
        rdata <= 8'h00;
      end
    end
  end
endmodule

//--- logic/crri_map.vh
`ifndef CRRI_MAP_VH
`define CRRI_MAP_VH
// =====================================================================
// register indices
`define CRRI_A_STACK_TOP_UPPER 5'h00
`define CRRI_A_STACK_TOP_HIGH 5'h01
`define CRRI_A_STACK_TOP_LOW 5'h02
`define CRRI_A_SPTR 5'h03
`define CRRI_A_PCLU 5'h04
`define CRRI_A_PCLH 5'h05
`define CRRI_A_PCL 5'h06
`define CRRI_A_TBU 5'h07
`define CRRI_A_TBH 5'h08
`define CRRI_A_TBL 5'h09
`define CRRI_A_TLAT 5'h0A
`define CRRI_A_PRH 5'h0B
`define CRRI_A_PRL 5'h0C
`define CRRI_A_IC1 5'h0D
`define CRRI_A_IC2 5'h0E
`define CRRI_A_IC3 5'h0F
`define CRRI_A_P0H 5'h10
`define CRRI_A_P0L 5'h11
`define CRRI_A_WRK 5'h12
`define CRRI_A_P1H 5'h13
`define CRRI_A_P1L 5'h14
`define CRRI_A_BSEL 5'h15
`define CRRI_A_RCS 5'h16
`define CRRI_A_PIRF 5'h17
`define CRRI_A_PORT_A_PINS 5'h18
`define CRRI_A_PWM 5'h19
`define CRRI_A_IST 5'h1A
`define CRRI_A_IMSK 5'h1B
// reset values, wake vectors and pc step
`define CRRI_RST_IC2 8'hFF
`define CRRI_RST_IC3 8'hC0
`define CRRI_VEC_HI 21'h000008
`define CRRI_VEC_LO 21'h000018
`define CRRI_PC_STEP 21'h000002
// fields
`define CRRI_SP_MASK 8'hDF
`define CRRI_SP_FULL 7
`define CRRI_SP_UNF 6
`define CRRI_IC1_GLOBAL_IRQ_ENABLE_HIGH 7
`define CRRI_IC1_GLOBAL_IRQ_ENABLE_LOW 6
`define CRRI_RC_SOFT_BROWNOUT_ENABLE 6
`define CRRI_RC_RI 4
`define CRRI_RC_TO 3
`define CRRI_RC_PD 2
`define CRRI_RC_POR 1
`define CRRI_RC_BOR 0
`define CRRI_BOR_SOFT 2'b01
`endif

//--- sim/crri_core_asserts.sv
`timescale 1ns/1ns
`include "crri_map.vh"
module crri_core_asserts #(
  parameter PWM_W = 4
) (
  input wire clk,
  input wire rst_b,
  input wire ev_por,
  input wire ev_bor,
  input wire ev_clr,
  input wire ev_wdt_rst,
  input wire ev_rst_inst,
  input wire ev_stk_full,
  input wire ev_stk_unf,
  input wire ev_wake_wdt,
  input wire ev_wake_irq,
  input wire wake_hi_prio,
  input wire [20:0] pc_now,
  input wire osc_frees_ra67,
  input wire pwm_pin_reset_mode,
  input wire [4:0] addr,
  input wire [7:0] wdata,
  input wire wr,
  input wire rd,
  input wire [7:0] rdata,
  input wire [20:0] pc_out,
  input wire [7:0] port_a_latch_out,
  input wire [7:0] port_a_dir_out,
  input wire [PWM_W-1:0] pwm_output_enable
);
  wire rst_any = ev_clr | ev_wdt_rst | ev_rst_inst | ev_stk_full | ev_stk_unf;
  wire pwr = ev_por | ev_bor;
  wire ev_any = rst_any | pwr | ev_wake_wdt | ev_wake_irq;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // =====================================================================
  // properties
  sequence s_por_rd;
    ev_por ##1 (rd && addr == `CRRI_A_IC2);
  endsequence
  property p_por_ic2;
    s_por_rd |=> rdata == `CRRI_RST_IC2;
  endproperty
  a_por_ic2: assert property (p_por_ic2) else $error("irq two not preset");
  property p_por_pc;
    pwr |=> pc_out == 21'h000000;
  endproperty
  a_por_pc: assert property (p_por_pc) else $error("pc not cleared");
  property p_rst_pc;
    rst_any |=> pc_out == 21'h000000;
  endproperty
  a_rst_pc: assert property (p_rst_pc) else $error("pc not cleared");
  property p_pwm;
    (pwr || rst_any) |=>
      pwm_output_enable == {PWM_W{!$past(pwm_pin_reset_mode)}};
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm enable reset wrong");
  property p_wdt_wake;
    ev_wake_wdt && !rst_any && !pwr |=>
      pc_out == $past(pc_now) + `CRRI_PC_STEP;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("wake pc wrong");
  property p_irq_wake;
    ev_wake_irq && !rst_any && !pwr |=>
      pc_out == $past(pc_now) + `CRRI_PC_STEP ||
      pc_out == ($past(wake_hi_prio) ? `CRRI_VEC_HI : `CRRI_VEC_LO);
  endproperty
  a_irq_wake: assert property (p_irq_wake) else $error("vector wrong");
  property p_hold;
    !ev_any && !wr |=> $stable(pc_out);
  endproperty
  a_hold: assert property (p_hold) else $error("pc moved idle");
  property p_pcl_wr;
    wr && addr == `CRRI_A_PCL && !ev_any |=> pc_out[7:0] == $past(wdata);
  endproperty
  a_pcl_wr: assert property (p_pcl_wr) else $error("pc low not loaded");
  sequence s_ra_off;
    !osc_frees_ra67 ##1 !osc_frees_ra67;
  endsequence
  property p_ra67;
    s_ra_off |-> port_a_dir_out[7:6] == 2'b00 &&
      port_a_latch_out[7:6] == 2'b00;
  endproperty
  a_ra67: assert property (p_ra67) else $error("port bits 7:6 live");
  property p_unmapped;
    rd && addr > `CRRI_A_IMSK |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("hole read");
endmodule
bind crri_core crri_core_asserts #(.PWM_W(PWM_W)) i_crri_core_asserts (.*);

//--- sim/crri_core_bench.sv
`timescale 1ns/1ns
`include "crri_map.vh"
module crri_core_bench;
  logic clk = 0, rst_b = 0, hp = 0, slp = 0, osc = 0, pwp = 0;
  logic wr = 0, rd = 0, irq;
  logic [8:0] ev = 0;
  logic [7:0] icb = 0, pirb = 0, pa = 0, wd = 0, rdata, pal, pad, spx = 0;
  logic [7:0] wv [22];
  logic [20:0] pcn = 0, pco;
  logic [1:0] bcf = 2'h1;
  logic [4:0] ad = 0;
  logic [3:0] pwe;
  int bad_count = 0, check_count = 0, s;
  crri_core i_crri_core (.clk(clk), .rst_b(rst_b), .ev_por(ev[0]),
    .ev_bor(ev[1]), .ev_clr(ev[2]), .ev_wdt_rst(ev[3]),
    .ev_rst_inst(ev[4]), .ev_stk_full(ev[5]), .ev_stk_unf(ev[6]),
    .ev_wake_wdt(ev[7]), .ev_wake_irq(ev[8]), .wake_hi_prio(hp),
    .wake_ic_bits(icb), .wake_pir_bits(pirb), .in_sleep(slp),
    .pc_now(pcn), .brownout_config_field(bcf), .osc_frees_ra67(osc),
    .pwm_pin_reset_mode(pwp), .port_a_in(pa), .addr(ad), .wdata(wd),
    .wr(wr), .rd(rd), .rdata(rdata), .pc_out(pco),
    .port_a_latch_out(pal), .port_a_dir_out(pad),
    .pwm_output_enable(pwe), .irq(irq));
  always #10 clk = ~clk;
  // =====================================================================
  // helpers
  task chk(input logic [20:0] g, input logic [20:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task wt(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    ad <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk);
    wr <= 0;
  endtask
  task rt(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    ad <= a;
    rd <= 1;
    @(posedge clk);
    rd <= 0;
    #1 chk(rdata, e);
  endtask
  task pulse(input int i);
    @(posedge clk);
    ev[i] <= 1;
    @(posedge clk);
    ev <= 0;
    #1 chk(pwe, (i < 7) ? {4{~pwp}} : pwe);
  endtask
  // kept bytes survive resets, the rest take preset values
  function logic [7:0] ex(input int i);
    if (i == 3)
      return spx;
    if (i == 14)
      return `CRRI_RST_IC2;
    if (i == 15)
      return `CRRI_RST_IC3;
    if (i == 11 || i == 12 || i == 17 || i == 18 || i == 20)
      return wv[i];
    return 8'h00;
  endfunction
  task complete_run;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    bad_count++;
    complete_run;
  end
  // =====================================================================
  // scenarios
  initial begin
    s = $urandom(64974);
    foreach (wv[i]) wv[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst_b <= 1;
    pulse(0);
    for (int i = 0; i < 22; i++) rt(i[4:0], ex(i));
    rt(`CRRI_A_RCS, 8'h5C);
    pulse(4);
    rt(`CRRI_A_RCS, 8'h4C);
    bcf <= 2'h0;
    pulse(2);
    rt(`CRRI_A_RCS, 8'h0C);
    for (int k = 2; k < 7; k++) begin
      for (int i = 0; i < 22; i++) begin
        wv[i] = $urandom;
        if (i != 3 && (i < 13 || i > 15)) wt(i[4:0], wv[i]);
      end
      pwp <= $urandom;
      // stack full and underflow resets set their sticky flags
      if (k == 5) spx = 8'h80;
      if (k == 6) spx = 8'hC0;
      pulse(k);
      chk(pco, 21'h000000);
      for (int i = 0; i < 22; i++) rt(i[4:0], ex(i));
    end
    wt(`CRRI_A_SPTR, 8'h20);
    rt(`CRRI_A_SPTR, 8'h00);
    for (int h = 0; h < 2; h++) begin
      wt(`CRRI_A_SPTR, 8'h03);
      wt(`CRRI_A_IC1, 8'hC0);
      wt(`CRRI_A_PIRF, 8'h00);
      pcn <= $urandom;
      hp <= h;
      icb <= $urandom;
      pirb <= $urandom;
      slp <= 1;
      pulse(8);
      chk(pco, h ? `CRRI_VEC_HI : `CRRI_VEC_LO);
      rt(`CRRI_A_STACK_TOP_UPPER, {3'h0, pcn[20:16]});
      rt(`CRRI_A_STACK_TOP_LOW, pcn[7:0]);
      rt(`CRRI_A_SPTR, 8'h04);
      rt(`CRRI_A_IC1, 8'hC0 | icb);
      rt(`CRRI_A_PIRF, pirb);
    end
    pulse(7);
    chk(pco, pcn + `CRRI_PC_STEP);
    rt(`CRRI_A_STACK_TOP_HIGH, pcn[15:8]);
    wt(`CRRI_A_IC1, 8'h00);
    pulse(8);
    chk(pco, pcn + `CRRI_PC_STEP);
    // pin reads pass a two-flop synchroniser, so allow settling first
    pa <= $urandom;
    wt(`CRRI_A_PWM, 8'hFF);
    rt(`CRRI_A_PWM, 8'h3F);
    rt(`CRRI_A_PORT_A_PINS, pa & 8'h3F);
    osc <= 1;
    wt(`CRRI_A_PWM, 8'hFF);
    rt(`CRRI_A_PWM, 8'hFF);
    rt(`CRRI_A_PORT_A_PINS, pa);
    wt(`CRRI_A_IMSK, 8'h03);
    rt(`CRRI_A_IST, 8'h03);
    chk(irq, 1'b1);
    wt(`CRRI_A_IST, 8'h03);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    pulse(7);
    wt(`CRRI_A_IMSK, 8'h02);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b0);
    wt(`CRRI_A_IMSK, 8'h01);
    repeat (2) @(posedge clk);
    #1 chk(irq, 1'b1);
    wt(5'h1C, 8'hFF);
    for (int i = 28; i < 32; i++) rt(i[4:0], 8'h00);
    complete_run;
  end
endmodule
